// file: inc/cmd_fifo_ctrl_pkg.sv
// Constants, types and state layout of the command and FIFO control register bank
// How it works
// - Standby bit enters power-down mode
// - Radio power-off bit powers receiver, transmitter down
// - Command register holds 5-bit command code
// - Unlock bit permits next host-access modification
// - Following write clears unlock automatically
// - Bus ownership bits change only when unlocked
// - Both ownership bits never set together
// - Module port select encodes four interface modes
// - Capacity select: 1 gives 255, 0 gives 512
// - Near-full when capacity minus count <= threshold
// - Near-empty when count <= threshold
// - Buffer clear empties buffer, reads zero
// - Threshold bit 8 used only in 512 mode
// - Count upper bits read-only, 512 mode only
// - Threshold register holds low threshold bits
// - Port write increments count, read decrements
// - Buffer port access keeps address pointer
// - Length register reports low count bits
package cmd_fifo_ctrl_pkg;
   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 8;
   localparam int COUNT_W = 10;
   localparam int THR_W   = 9;
   localparam int CODE_W  = 5;
   localparam int SEL_W   = 2;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] OFF_COMMAND = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_HOST    = 8'h01;
   localparam logic [ADDR_W-1:0] OFF_FIFOCFG = 8'h02;
   localparam logic [ADDR_W-1:0] OFF_THRESH  = 8'h03;
   localparam logic [ADDR_W-1:0] OFF_LENGTH  = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_PORT    = 8'h05;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int BIT_STANDBY   = 7;
   localparam int BIT_RADIO_OFF = 6;
   localparam int CODE_LSB      = 0;
   localparam int BIT_UNLOCK    = 7;
   localparam int BIT_HOST_BUS  = 6;
   localparam int BIT_MOD_BUS   = 5;
   localparam int SEL_LSB       = 2;
   localparam int BIT_CAP_SEL   = 7;
   localparam int BIT_NEAR_FULL = 6;
   localparam int BIT_NEAR_EMPT = 5;
   localparam int BIT_CLEAR     = 4;
   localparam int BIT_THR8      = 2;
   localparam int CNT_UP_LSB    = 0;

   // ----------------------------------------
   // Capacities, encodings and reset values
   // ----------------------------------------
   localparam logic [COUNT_W-1:0] CAP_SMALL = 10'h0FF;
   localparam logic [COUNT_W-1:0] CAP_LARGE = 10'h200;
   localparam logic [COUNT_W-1:0] COUNT_ONE = 10'h001;
   localparam logic [ADDR_W-1:0]  ADDR_ONE  = 8'h01;
   localparam logic [DATA_W-1:0]  ZERO_BYTE = 8'h00;

   typedef enum logic [SEL_W-1:0] {
      PORT_OFF, PORT_SPI, PORT_TWO_WIRE_LV, PORT_TWO_WIRE
   } port_sel_t;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_req_t;

   typedef struct packed {
      logic              standby;
      logic              radio_power_off;
      logic [CODE_W-1:0] command_code;
      logic              access_unlock;
      logic              host_owns_bus;
      logic              module_owns_bus;
      port_sel_t         module_port_select;
      logic              buffer_capacity_select;
      logic              threshold_bit8;
      logic [7:0]        threshold_low_bits;
      logic [COUNT_W-1:0] byte_count;
      logic              buffer_clear;
      logic              push;
      logic [DATA_W-1:0] push_data;
      logic [DATA_W-1:0] rdata;
      logic [ADDR_W-1:0] addr_ptr;
   } state_t;

   localparam state_t STATE_RESET = '0;
endpackage : cmd_fifo_ctrl_pkg

// file: src/command_fifo_control_regs.sv
// Command, host-access and FIFO control register bank with byte counter
`timescale 1ns/1ps
module command_fifo_control_regs
(
   // Clock and reset
   input  wire logic                                    ref_clk,
   input  wire logic                                    rst_n,
   // Register port
   input  wire cmd_fifo_ctrl_pkg::reg_req_t             req,
   output logic [cmd_fifo_ctrl_pkg::DATA_W-1:0]         rdata,
   output logic [cmd_fifo_ctrl_pkg::ADDR_W-1:0]         next_addr,
   // Buffer storage side
   input  wire logic [cmd_fifo_ctrl_pkg::DATA_W-1:0]    buffer_head,
   output logic                                         buffer_push,
   output logic [cmd_fifo_ctrl_pkg::DATA_W-1:0]         buffer_push_data,
   output logic                                         buffer_pop,
   output logic                                         buffer_clear,
   output logic [cmd_fifo_ctrl_pkg::COUNT_W-1:0]        byte_count,
   output logic                                         near_full_flag,
   output logic                                         near_empty_flag,
   // Controls to the rest of the device
   output logic                                         standby,
   output logic                                         radio_power_off,
   output logic [cmd_fifo_ctrl_pkg::CODE_W-1:0]         command_code,
   output logic                                         host_owns_bus,
   output logic                                         module_owns_bus,
   output cmd_fifo_ctrl_pkg::port_sel_t                 module_port_select,
   output logic                                         buffer_capacity_select
);

   // ----------------------------------------
   // Decode helper
   // ----------------------------------------
   function automatic logic hit(input logic [cmd_fifo_ctrl_pkg::ADDR_W-1:0] a,
                                input logic [cmd_fifo_ctrl_pkg::ADDR_W-1:0] off);
      hit = (a == off);
   endfunction : hit

   cmd_fifo_ctrl_pkg::state_t st_q;
   cmd_fifo_ctrl_pkg::state_t st_d;

   logic [cmd_fifo_ctrl_pkg::COUNT_W-1:0] capacity;
   logic [cmd_fifo_ctrl_pkg::COUNT_W-1:0] thr_eff;
   logic [cmd_fifo_ctrl_pkg::COUNT_W-1:0] room;
   logic                                  full;
   logic                                  empty;
   logic                                  do_push;
   logic                                  do_pop;

   // ----------------------------------------
   // Capacity and threshold
   // ----------------------------------------
   // capacity from select bit
   assign capacity = st_q.buffer_capacity_select ? cmd_fifo_ctrl_pkg::CAP_SMALL : cmd_fifo_ctrl_pkg::CAP_LARGE;
   // bit 8 only in large mode
   assign thr_eff  = {1'b0, (st_q.threshold_bit8 & ~st_q.buffer_capacity_select), st_q.threshold_low_bits};
   assign room     = capacity - st_q.byte_count;
   assign full     = (st_q.byte_count >= capacity);
   assign empty    = (st_q.byte_count == '0);

   // ----------------------------------------
   // Alert flags
   // ----------------------------------------
   // near full comparison
   assign near_full_flag  = (room <= thr_eff);
   assign near_empty_flag = (st_q.byte_count <= thr_eff);

   // Pushes beyond capacity and pops from empty are dropped to keep the count honest
   // port accesses move count
   assign do_push = req.wr & hit(req.addr, cmd_fifo_ctrl_pkg::OFF_PORT) & ~full;
   assign do_pop  = req.rd & hit(req.addr, cmd_fifo_ctrl_pkg::OFF_PORT) & ~empty;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      st_d              = st_q;
      st_d.buffer_clear = 1'b0;
      st_d.push         = 1'b0;
      st_d.rdata        = cmd_fifo_ctrl_pkg::ZERO_BYTE;

      if (req.wr)
      begin
         st_d.access_unlock = 1'b0;
         case (req.addr)
            cmd_fifo_ctrl_pkg::OFF_COMMAND:
            begin
               st_d.standby         = req.wdata[cmd_fifo_ctrl_pkg::BIT_STANDBY];
               st_d.radio_power_off = req.wdata[cmd_fifo_ctrl_pkg::BIT_RADIO_OFF];
               st_d.command_code    = req.wdata[cmd_fifo_ctrl_pkg::CODE_LSB +: cmd_fifo_ctrl_pkg::CODE_W];
            end
            cmd_fifo_ctrl_pkg::OFF_HOST:
            begin
               st_d.access_unlock = req.wdata[cmd_fifo_ctrl_pkg::BIT_UNLOCK];
               if (st_q.access_unlock &&
                   !(req.wdata[cmd_fifo_ctrl_pkg::BIT_HOST_BUS] && req.wdata[cmd_fifo_ctrl_pkg::BIT_MOD_BUS]))
               begin
                  st_d.host_owns_bus   = req.wdata[cmd_fifo_ctrl_pkg::BIT_HOST_BUS];
                  st_d.module_owns_bus = req.wdata[cmd_fifo_ctrl_pkg::BIT_MOD_BUS];
               end
               st_d.module_port_select =
                  cmd_fifo_ctrl_pkg::port_sel_t'(req.wdata[cmd_fifo_ctrl_pkg::SEL_LSB +: cmd_fifo_ctrl_pkg::SEL_W]);
            end
            cmd_fifo_ctrl_pkg::OFF_FIFOCFG:
            begin
               st_d.buffer_capacity_select = req.wdata[cmd_fifo_ctrl_pkg::BIT_CAP_SEL];
               st_d.threshold_bit8         = req.wdata[cmd_fifo_ctrl_pkg::BIT_THR8];
               st_d.buffer_clear           = req.wdata[cmd_fifo_ctrl_pkg::BIT_CLEAR];
            end
            cmd_fifo_ctrl_pkg::OFF_THRESH:
            begin
               st_d.threshold_low_bits = req.wdata;
            end
            cmd_fifo_ctrl_pkg::OFF_PORT:
            begin
               st_d.push      = do_push;
               st_d.push_data = req.wdata;
            end
            default:
            begin
               st_d.access_unlock = 1'b0;
            end
         endcase
      end

      if (req.rd)
      begin
         case (req.addr)
            cmd_fifo_ctrl_pkg::OFF_COMMAND:
            begin
               st_d.rdata[cmd_fifo_ctrl_pkg::BIT_STANDBY]   = st_q.standby;
               st_d.rdata[cmd_fifo_ctrl_pkg::BIT_RADIO_OFF] = st_q.radio_power_off;
               st_d.rdata[cmd_fifo_ctrl_pkg::CODE_LSB +: cmd_fifo_ctrl_pkg::CODE_W] = st_q.command_code;
            end
            cmd_fifo_ctrl_pkg::OFF_HOST:
            begin
               st_d.rdata[cmd_fifo_ctrl_pkg::BIT_UNLOCK]   = st_q.access_unlock;
               st_d.rdata[cmd_fifo_ctrl_pkg::BIT_HOST_BUS] = st_q.host_owns_bus;
               st_d.rdata[cmd_fifo_ctrl_pkg::BIT_MOD_BUS]  = st_q.module_owns_bus;
               st_d.rdata[cmd_fifo_ctrl_pkg::SEL_LSB +: cmd_fifo_ctrl_pkg::SEL_W] = st_q.module_port_select;
            end
            cmd_fifo_ctrl_pkg::OFF_FIFOCFG:
            begin
               st_d.rdata[cmd_fifo_ctrl_pkg::BIT_CAP_SEL]   = st_q.buffer_capacity_select;
               st_d.rdata[cmd_fifo_ctrl_pkg::BIT_NEAR_FULL] = near_full_flag;
               st_d.rdata[cmd_fifo_ctrl_pkg::BIT_NEAR_EMPT] = near_empty_flag;
               st_d.rdata[cmd_fifo_ctrl_pkg::BIT_THR8]      = st_q.threshold_bit8;
               // upper count bits in large mode
               st_d.rdata[cmd_fifo_ctrl_pkg::CNT_UP_LSB +: 2] =
                  st_q.buffer_capacity_select ? 2'h0 : st_q.byte_count[9:8];
            end
            cmd_fifo_ctrl_pkg::OFF_THRESH:
            begin
               st_d.rdata = st_q.threshold_low_bits;
            end
            cmd_fifo_ctrl_pkg::OFF_LENGTH:
            begin
               st_d.rdata = st_q.byte_count[7:0];
            end
            cmd_fifo_ctrl_pkg::OFF_PORT:
            begin
               st_d.rdata = do_pop ? buffer_head : cmd_fifo_ctrl_pkg::ZERO_BYTE;
            end
            default:
            begin
               st_d.rdata = cmd_fifo_ctrl_pkg::ZERO_BYTE;
            end
         endcase
      end

      if (st_d.buffer_clear)
      begin
         st_d.byte_count = '0;
      end
      else if (do_push)
      begin
         st_d.byte_count = st_q.byte_count + cmd_fifo_ctrl_pkg::COUNT_ONE;
      end
      else if (do_pop)
      begin
         st_d.byte_count = st_q.byte_count - cmd_fifo_ctrl_pkg::COUNT_ONE;
      end

      if (req.wr || req.rd)
      begin
         st_d.addr_ptr = hit(req.addr, cmd_fifo_ctrl_pkg::OFF_PORT) ? req.addr
                                                                   : req.addr + cmd_fifo_ctrl_pkg::ADDR_ONE;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= cmd_fifo_ctrl_pkg::STATE_RESET;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign rdata                  = st_q.rdata;
   assign next_addr              = st_q.addr_ptr;
   assign buffer_push            = st_q.push;
   assign buffer_push_data       = st_q.push_data;
   assign buffer_pop             = do_pop;
   assign buffer_clear           = st_q.buffer_clear;
   assign byte_count             = st_q.byte_count;
   assign standby                = st_q.standby;
   assign radio_power_off        = st_q.radio_power_off;
   assign command_code           = st_q.command_code;
   assign host_owns_bus          = st_q.host_owns_bus;
   assign module_owns_bus        = st_q.module_owns_bus;
   assign module_port_select     = st_q.module_port_select;
   assign buffer_capacity_select = st_q.buffer_capacity_select;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_standby_write: assert property (
      req.wr && hit(req.addr, cmd_fifo_ctrl_pkg::OFF_COMMAND) |=> standby == $past(req.wdata[7]))
      else $error("standby did not follow command write");
   a_radio_off_write: assert property (
      req.wr && hit(req.addr, cmd_fifo_ctrl_pkg::OFF_COMMAND) |=> radio_power_off == $past(req.wdata[6]))
      else $error("radio power-off did not follow command write");
   a_code_write: assert property (
      req.wr && hit(req.addr, cmd_fifo_ctrl_pkg::OFF_COMMAND) |=> command_code == $past(req.wdata[4:0]))
      else $error("command code did not follow write");
   a_unlock_self_clear: assert property (
      req.wr && !(hit(req.addr, cmd_fifo_ctrl_pkg::OFF_HOST) && req.wdata[7]) |=> !st_q.access_unlock)
      else $error("unlock survived a write");
   a_bus_locked_hold: assert property (
      req.wr && !st_q.access_unlock |=> $stable(host_owns_bus) && $stable(module_owns_bus))
      else $error("ownership changed while locked");
   a_bus_exclusive: assert property (
      !(host_owns_bus && module_owns_bus))
      else $error("both bus owners set");
   a_clear_reads_zero: assert property (
      req.rd && hit(req.addr, cmd_fifo_ctrl_pkg::OFF_FIFOCFG) |=> rdata[4] == 1'b0)
      else $error("clear bit read back as one");
   a_clear_empties: assert property (
      req.wr && hit(req.addr, cmd_fifo_ctrl_pkg::OFF_FIFOCFG) && req.wdata[4] |=> byte_count == '0)
      else $error("clear did not empty count");
   a_near_empty_value: assert property (
      near_empty_flag == (byte_count <= {1'b0, st_q.threshold_bit8 & ~buffer_capacity_select,
                                         st_q.threshold_low_bits}))
      else $error("near empty flag wrong");
   a_count_push_step: assert property (
      do_push |=> byte_count == $past(byte_count) + 10'h001)
      else $error("count did not step on push");
   a_count_pop_step: assert property (
      do_pop ##1 !$past(req.wr) |-> byte_count == $past(byte_count) - 10'h001)
      else $error("count did not step on pop");
   a_port_ptr_hold: assert property (
      (req.wr || req.rd) && hit(req.addr, cmd_fifo_ctrl_pkg::OFF_PORT) |=> next_addr == cmd_fifo_ctrl_pkg::OFF_PORT)
      else $error("pointer moved on port access");
   a_length_read: assert property (
      req.rd && hit(req.addr, cmd_fifo_ctrl_pkg::OFF_LENGTH) |=> rdata == $past(byte_count[7:0]))
      else $error("length read wrong");
   a_reserved_cmd: assert property (
      req.rd && hit(req.addr, cmd_fifo_ctrl_pkg::OFF_COMMAND) |=> rdata[5] == 1'b0)
      else $error("reserved command bit read one");
   a_unlock_arm: assert property (
      req.wr && hit(req.addr, cmd_fifo_ctrl_pkg::OFF_HOST) && req.wdata[7] |=> st_q.access_unlock)
      else $error("unlock bit not armed");
   a_bus_unlocked_set: assert property (
      st_q.access_unlock && req.wr && hit(req.addr, cmd_fifo_ctrl_pkg::OFF_HOST) && !(req.wdata[6] && req.wdata[5])
      |=> host_owns_bus == $past(req.wdata[6]) && module_owns_bus == $past(req.wdata[5]))
      else $error("ownership not taken while unlocked");
   a_bus_both_reject: assert property (
      req.wr && hit(req.addr, cmd_fifo_ctrl_pkg::OFF_HOST) && req.wdata[6] && req.wdata[5]
      |=> $stable(host_owns_bus) && $stable(module_owns_bus))
      else $error("double ownership write accepted");
   a_select_write: assert property (
      req.wr && hit(req.addr, cmd_fifo_ctrl_pkg::OFF_HOST) |=> module_port_select == $past(req.wdata[3:2]))
      else $error("port select did not follow write");
   a_capacity_write: assert property (
      req.wr && hit(req.addr, cmd_fifo_ctrl_pkg::OFF_FIFOCFG) |=> buffer_capacity_select == $past(req.wdata[7]))
      else $error("capacity select did not follow write");
   a_near_full_value: assert property (
      near_full_flag == ((buffer_capacity_select ? cmd_fifo_ctrl_pkg::CAP_SMALL : cmd_fifo_ctrl_pkg::CAP_LARGE)
                         - byte_count <= {1'b0, st_q.threshold_bit8 & ~buffer_capacity_select,
                                          st_q.threshold_low_bits}))
      else $error("near full flag wrong");
   a_clear_pulse: assert property (
      req.wr && hit(req.addr, cmd_fifo_ctrl_pkg::OFF_FIFOCFG) |=> buffer_clear == $past(req.wdata[4]))
      else $error("clear pulse did not follow write");
   a_thr8_ignored: assert property (
      buffer_capacity_select && st_q.threshold_bit8
      |-> near_full_flag == (cmd_fifo_ctrl_pkg::CAP_SMALL - byte_count <= {2'b00, st_q.threshold_low_bits}))
      else $error("threshold bit 8 used in small mode");
   a_upper_bits_read: assert property (
      req.rd && hit(req.addr, cmd_fifo_ctrl_pkg::OFF_FIFOCFG)
      |=> rdata[1:0] == ($past(buffer_capacity_select) ? 2'h0 : $past(byte_count[9:8])))
      else $error("upper count bits read wrong");
   a_thresh_write: assert property (
      req.wr && hit(req.addr, cmd_fifo_ctrl_pkg::OFF_THRESH) |=> st_q.threshold_low_bits == $past(req.wdata))
      else $error("threshold did not follow write");
   a_push_pulse: assert property (
      do_push |=> buffer_push && buffer_push_data == $past(req.wdata))
      else $error("push pulse or data wrong");
   a_ptr_step: assert property (
      (req.wr || req.rd) && !hit(req.addr, cmd_fifo_ctrl_pkg::OFF_PORT) |=> next_addr == $past(req.addr) + 8'h01)
      else $error("pointer did not advance");
   a_unmapped_read: assert property (
      req.rd && req.addr > cmd_fifo_ctrl_pkg::OFF_PORT |=> rdata == 8'h00)
      else $error("unmapped read not zero");

   c_unlock_then_own: cover property (
      st_q.access_unlock && req.wr && hit(req.addr, cmd_fifo_ctrl_pkg::OFF_HOST) ##1 host_owns_bus);
   c_near_full: cover property (near_full_flag && !near_empty_flag);
   c_large_upper: cover property (byte_count[9]);
   c_clear_seen: cover property (buffer_clear);
   c_small_full: cover property (buffer_capacity_select && near_full_flag);

endmodule : command_fifo_control_regs

// file: verification/buffer_store_model.sv
// Behavioural byte storage that sits behind the counter
`timescale 1ns/1ps
module buffer_store_model
(
   // Clock and reset
   input  wire logic                                 ref_clk,
   input  wire logic                                 rst_n,
   // Counter side
   input  wire logic                                 buffer_push,
   input  wire logic [cmd_fifo_ctrl_pkg::DATA_W-1:0] buffer_push_data,
   input  wire logic                                 buffer_pop,
   input  wire logic                                 buffer_clear,
   output logic [cmd_fifo_ctrl_pkg::DATA_W-1:0]      buffer_head
);
   logic [7:0] mem [0:511];
   logic [8:0] wr_ptr;
   logic [8:0] rd_ptr;
   logic [9:0] fill;
   logic [7:0] last;

   // Push lands one cycle after the count moves, so an empty store forwards it
   // Otherwise an empty store shows a changing pattern so a stale byte never passes
   assign buffer_head = (fill != 10'h000) ? mem[rd_ptr] : (buffer_push ? buffer_push_data : ~last);

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr <= 9'h000;
         rd_ptr <= 9'h000;
         fill   <= 10'h000;
         last   <= 8'h00;
      end
      else
      begin
         last <= buffer_head;
         if (buffer_clear)
         begin
            wr_ptr <= 9'h000;
            rd_ptr <= 9'h000;
            fill   <= 10'h000;
         end
         else
         begin
            if (buffer_push)
            begin
               mem[wr_ptr] <= buffer_push_data;
               wr_ptr      <= wr_ptr + 9'h001;
            end
            if (buffer_pop)
               rd_ptr <= rd_ptr + 9'h001;
            fill <= fill + 10'(buffer_push) - 10'(buffer_pop);
         end
      end
   end
endmodule : buffer_store_model

// file: verification/tb_top.sv
// Self-checking bench for the command and FIFO control register bank
`timescale 1ns/1ps
module tb_top;
   logic                          ref_clk = 1'b0;
   logic                          rst_n   = 1'b0;
   cmd_fifo_ctrl_pkg::reg_req_t   req     = '0;
   logic [7:0]                    rdata, next_addr, buffer_head, buffer_push_data;
   logic                          buffer_push, buffer_pop, buffer_clear, near_full_flag, near_empty_flag;
   logic [9:0]                    byte_count;
   logic                          standby, radio_power_off, host_owns_bus, module_owns_bus, buffer_capacity_select;
   logic [4:0]                    command_code;
   cmd_fifo_ctrl_pkg::port_sel_t  module_port_select;
   int                            n_mismatch = 0;
   int                            checked    = 0;
   int                            cycles     = 0;
   typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] exp;} row_t;
   row_t rows [6] = '{'{8'h00, 8'hFF, 8'hDF}, '{8'h03, 8'h5A, 8'h5A}, '{8'h01, 8'h1F, 8'h0C},
                      '{8'h04, 8'h33, 8'h00}, '{8'h10, 8'h77, 8'h00}, '{8'h00, 8'hC3, 8'hC3}};

   always #25 ref_clk = ~ref_clk;

   command_fifo_control_regs i_command_fifo_control_regs
   (
      .ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rdata(rdata), .next_addr(next_addr),
      .buffer_head(buffer_head), .buffer_push(buffer_push), .buffer_push_data(buffer_push_data),
      .buffer_pop(buffer_pop), .buffer_clear(buffer_clear), .byte_count(byte_count),
      .near_full_flag(near_full_flag), .near_empty_flag(near_empty_flag), .standby(standby),
      .radio_power_off(radio_power_off), .command_code(command_code), .host_owns_bus(host_owns_bus),
      .module_owns_bus(module_owns_bus), .module_port_select(module_port_select),
      .buffer_capacity_select(buffer_capacity_select)
   );

   buffer_store_model i_buffer_store_model
   (
      .ref_clk(ref_clk), .rst_n(rst_n), .buffer_push(buffer_push), .buffer_push_data(buffer_push_data),
      .buffer_pop(buffer_pop), .buffer_clear(buffer_clear), .buffer_head(buffer_head)
   );

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      req.wr <= 1'b0;
      #1;
   endtask : wr

   task rchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      req.rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask : rchk

   task push_n(input int n);
      for (int i = 0; i < n; i++)
         wr(cmd_fifo_ctrl_pkg::OFF_PORT, 8'(8'hAA + i));
   endtask : push_n

   task summarize;
      $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize

   // Hang guard, well above the roughly 1200 cycles the run needs
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         n_mismatch++;
         summarize();
      end
   end

   initial
   begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      rchk(8'h00, 8'h00);
      rchk(8'h01, 8'h00);
      rchk(8'h02, 8'h20);
      rchk(8'h03, 8'h00);
      chk(next_addr, 8'h04);
      foreach (rows[i])
      begin
         wr(rows[i].addr, rows[i].wdata);
         rchk(rows[i].addr, rows[i].exp);
      end
      chk({standby, radio_power_off, command_code}, 16'h0063);
      for (int s = 0; s < 4; s++)
      begin
         wr(8'h01, 8'(s << 2));
         chk(16'(module_port_select), 16'(s));
      end
      // Ownership and one-shot unlock
      wr(8'h01, 8'h40);
      chk(host_owns_bus, 1'b0);
      wr(8'h01, 8'h80);
      rchk(8'h01, 8'h80);
      wr(8'h01, 8'h40);
      rchk(8'h01, 8'h40);
      wr(8'h01, 8'h80);
      wr(8'h01, 8'h60);
      chk({host_owns_bus, module_owns_bus}, 16'h0002);
      wr(8'h01, 8'h80);
      wr(8'h01, 8'h20);
      chk({host_owns_bus, module_owns_bus}, 16'h0001);
      wr(8'h01, 8'h80);
      wr(8'h00, 8'h00);
      wr(8'h01, 8'h40);
      chk({host_owns_bus, module_owns_bus}, 16'h0001);
      // Count, thresholds and flags in 512-byte mode
      wr(8'h03, 8'h00);
      push_n(3);
      chk(byte_count, 10'h003);
      chk(buffer_push, 1'b1);
      chk(buffer_push_data, 8'hAC);
      chk(next_addr, 8'h05);
      rchk(8'h04, 8'h03);
      wr(8'h03, 8'h03);
      chk(near_empty_flag, 1'b1);
      wr(8'h03, 8'h02);
      chk(near_empty_flag, 1'b0);
      wr(8'h02, 8'h04);
      wr(8'h03, 8'hFD);
      chk(near_full_flag, 1'b1);
      rchk(8'h02, 8'h64);
      wr(8'h03, 8'hFC);
      chk(near_full_flag, 1'b0);
      rchk(8'h05, 8'hAA);
      chk(byte_count, 10'h002);
      // Clear before the size change
      // host clears first
      wr(8'h02, 8'h10);
      chk(byte_count, 10'h000);
      chk(buffer_clear, 1'b1);
      rchk(8'h02, 8'h20);
      rchk(8'h05, 8'h00);
      chk(byte_count, 10'h000);
      // 255-byte mode ignores threshold bit 8 and upper count bits
      wr(8'h02, 8'h84);
      push_n(2);
      chk({buffer_capacity_select, near_full_flag}, 16'h0002);
      wr(8'h03, 8'hFD);
      chk(near_full_flag, 1'b1);
      rchk(8'h02, 8'hE4);
      rchk(8'h05, 8'hAA);
      rchk(8'h05, 8'hAB);
      wr(8'h02, 8'h10);
      wr(8'h02, 8'h00);
      wr(8'h03, 8'h00);
      // Fill to the 512-byte limit and past it
      push_n(257);
      rchk(8'h02, 8'h01);
      rchk(8'h04, 8'h01);
      push_n(256);
      chk(byte_count, 10'h200);
      rchk(8'h02, 8'h42);
      wr(8'h02, 8'h10);
      chk(byte_count, 10'h000);
      // Back-to-back push and pop with no idle cycle between strobes
      @(posedge ref_clk);
      req <= '{addr: cmd_fifo_ctrl_pkg::OFF_PORT, wdata: 8'h5C, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      req <= '{addr: cmd_fifo_ctrl_pkg::OFF_PORT, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      req.rd <= 1'b0;
      #1;
      chk(rdata, 8'h5C);
      chk(byte_count, 10'h000);
      // Reset in mid-run returns every control to zero
      wr(8'h00, 8'hC3);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      #1;
      chk({standby, radio_power_off, command_code, next_addr}, 16'h0000);
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      rchk(8'h02, 8'h20);
      rchk(8'h00, 8'h00);
      summarize();
   end
endmodule : tb_top
